// File: design/tcg_pin_regs.sv
/*
 * tcg_pin_regs: second pin control register and pin data register with pin three/four logic.
 * assumes: one clock, inputs synchronous to it, pins one/two handled elsewhere but their data lives here.
 */
// Notes on behaviour
// - control bit 0 set lets pin four raise alert; clear masks it.
// - control bit 1 sets pin four direction: 0 output, 1 input.
// - control bit 2 sets pin four active level: 0 low, 1 high.
// - control bit 4 set lets pin three raise alert; clear masks it.
// - control bit 5 sets pin three direction when bit 7 is set: 0 output, 1 input.
// - control bit 6 sets pin three active level: 0 low, 1 high.
// - control bit 7 picks third aux input (0) or pin three (1).
// - data register written at extended 1111 0010, read at address 11101.
// - data bits 4..7 are pins four, three, two, one; bits 0..3 unused.
// - data register reads zero after reset.
`default_nettype none
module tcg_pin_regs
    import tcg_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        clk_en_in,
    input  wire logic        wr_valid_in,
    input  wire logic [15:0] wr_word_in,
    input  wire logic [4:0]  rd_addr_in,
    output logic      [11:0] rd_data_out,
    output logic             rd_hit_out,
    input  wire logic        pin_three_in,
    output logic             pin_three_out,
    output logic             pin_three_oe_out,
    input  wire logic        pin_four_in,
    output logic             pin_four_out,
    output logic             pin_four_oe_out,
    input  wire logic [1:0]  pin_low_dir_in,
    input  wire logic [1:0]  pin_low_level_in,
    output logic      [1:0]  pin_low_value_out,
    output logic             third_aux_select_out,
    output logic             alert_req_out
);
    import tcg_pkg::*;

    logic [7:0]  ctrl_two_ff;
    logic [7:0]  nxt_ctrl_two;
    logic [7:0]  pin_data_ff;
    logic [7:0]  nxt_pin_data;
    logic [11:0] rd_data_ff;
    logic [11:0] nxt_rd_data;
    logic        ext_wr;
    logic        p3_gpio;
    logic        p3_in_mode;
    logic        p4_in_mode;
    logic        p3_active;
    logic        p4_active;

    // only words carrying the extended prefix reach this map
    assign ext_wr     = wr_valid_in && (wr_word_in[WORD_PREFIX_HI -: 4] == EXT_WRITE_PREFIX);
    assign p3_gpio    = ctrl_two_ff[P3_FUNC_BIT];
    assign p3_in_mode = p3_gpio && ctrl_two_ff[P3_DIR_BIT];
    assign p4_in_mode = ctrl_two_ff[P4_DIR_BIT];
    // a pin is active when its level matches the programmed polarity
    assign p3_active  = (pin_three_in == ctrl_two_ff[P3_POL_BIT]);
    assign p4_active  = (pin_four_in == ctrl_two_ff[P4_POL_BIT]);

    always_comb begin
        nxt_ctrl_two = ctrl_two_ff;
        nxt_pin_data = pin_data_ff;
        if (ext_wr && (wr_word_in[WORD_ADDR_HI -: 4] == WADDR_CTRL_TWO)) begin
            nxt_ctrl_two = wr_word_in[WORD_DATA_HI -: 8];
        end
        if (ext_wr && (wr_word_in[WORD_ADDR_HI -: 4] == WADDR_PIN_DATA)) begin
            nxt_pin_data = wr_word_in[WORD_DATA_HI -: 8] & PIN_DATA_USED;
        end
        // sampled inputs win over a host write: the pin is the truth for an input
        if (p4_in_mode) begin
            nxt_pin_data[P4_DATA_BIT] = p4_active;
        end
        if (p3_in_mode) begin
            nxt_pin_data[P3_DATA_BIT] = p3_active;
        end
        if (pin_low_dir_in[0]) begin
            nxt_pin_data[P2_DATA_BIT] = pin_low_level_in[0];
        end
        if (pin_low_dir_in[1]) begin
            nxt_pin_data[P1_DATA_BIT] = pin_low_level_in[1];
        end
    end

    always_comb begin
        nxt_rd_data = READ_ZERO;
        if (rd_addr_in == RADDR_CTRL_TWO) begin
            nxt_rd_data = {4'h0, nxt_ctrl_two};
        end else if (rd_addr_in == RADDR_PIN_DATA) begin
            nxt_rd_data = {4'h0, nxt_pin_data};
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_two_ff <= CTRL_TWO_RESET;
            pin_data_ff <= PIN_DATA_RESET;
            rd_data_ff  <= READ_ZERO;
        end else if (clk_en_in) begin
            ctrl_two_ff <= nxt_ctrl_two;
            pin_data_ff <= nxt_pin_data;
            rd_data_ff  <= nxt_rd_data;
        end
    end

    assign rd_data_out          = rd_data_ff;
    assign rd_hit_out           = (rd_addr_in == RADDR_CTRL_TWO) || (rd_addr_in == RADDR_PIN_DATA);
    assign pin_low_value_out    = {pin_data_ff[P1_DATA_BIT], pin_data_ff[P2_DATA_BIT]};
    assign third_aux_select_out = !p3_gpio;
    // output drive: asserted data shows the programmed active level
    assign pin_four_oe_out      = !p4_in_mode;
    assign pin_four_out         = !(pin_data_ff[P4_DATA_BIT] ^ ctrl_two_ff[P4_POL_BIT]);
    assign pin_three_oe_out     = p3_gpio && !ctrl_two_ff[P3_DIR_BIT];
    assign pin_three_out        = !(pin_data_ff[P3_DATA_BIT] ^ ctrl_two_ff[P3_POL_BIT]);
    // alert request is a level; the shared alert pin logic lives outside
    assign alert_req_out = (ctrl_two_ff[P4_ALERT_BIT] && p4_in_mode && p4_active)
                         || (ctrl_two_ff[P3_ALERT_BIT] && p3_in_mode && p3_active);

    sequence data_write_s;
        clk_en_in && ext_wr && (wr_word_in[WORD_ADDR_HI -: 4] == WADDR_PIN_DATA) && !p4_in_mode;
    endsequence

    sequence data_read_s;
        clk_en_in && (rd_addr_in == RADDR_PIN_DATA);
    endsequence

    data_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        data_write_s |=> (pin_data_ff[P4_DATA_BIT] == $past(wr_word_in[P4_DATA_BIT])))
        else $error("pin data write lost");
    data_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        data_read_s |=> (rd_data_out == {4'h0, pin_data_ff}))
        else $error("pin data readback wrong");
    unused_bits_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        pin_data_ff[3:0] == 4'h0)
        else $error("unused data bits set");
    reset_zero_a: assert property (@(posedge clock_in)
        $rose(rst_b_in) |-> (pin_data_ff == PIN_DATA_RESET))
        else $error("data not zero after reset");
    four_alert_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!ctrl_two_ff[P4_ALERT_BIT] && !ctrl_two_ff[P3_ALERT_BIT]) |-> !alert_req_out)
        else $error("masked pin raised alert");
    three_alert_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (ctrl_two_ff[P3_ALERT_BIT] && p3_in_mode && p3_active) |-> alert_req_out)
        else $error("pin three alert missing");
    four_dir_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        pin_four_oe_out == !ctrl_two_ff[P4_DIR_BIT])
        else $error("pin four direction wrong");
    three_func_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !ctrl_two_ff[P3_FUNC_BIT] |-> (third_aux_select_out && !pin_three_oe_out))
        else $error("pin three driven in aux mode");
    input_sample_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (clk_en_in && p3_in_mode) |=> (pin_data_ff[P3_DATA_BIT] == $past(p3_active)))
        else $error("pin three input not sampled");
    four_pol_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!p4_in_mode && ctrl_two_ff[P4_POL_BIT]) |-> (pin_four_out == pin_data_ff[P4_DATA_BIT]))
        else $error("pin four polarity drive wrong");

    sequence ctrl_write_s;
        clk_en_in && ext_wr && (wr_word_in[WORD_ADDR_HI -: 4] == WADDR_CTRL_TWO);
    endsequence

    sequence foreign_word_s;
        clk_en_in && wr_valid_in && (wr_word_in[WORD_PREFIX_HI -: 4] != EXT_WRITE_PREFIX);
    endsequence

    sequence ctrl_read_s;
        clk_en_in && (rd_addr_in == RADDR_CTRL_TWO);
    endsequence

    sequence four_input_s;
        clk_en_in && p4_in_mode;
    endsequence

    // enables gate the pin level, so a masked pin can never leak through the other pin's term
    four_alert_on_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (ctrl_two_ff[P4_ALERT_BIT] && p4_in_mode && p4_active) |-> alert_req_out)
        else $error("pin four alert missing");
    four_mask_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!ctrl_two_ff[P4_ALERT_BIT] && !(ctrl_two_ff[P3_ALERT_BIT] && p3_in_mode)) |-> !alert_req_out)
        else $error("pin four alert not masked");
    three_mask_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!ctrl_two_ff[P3_ALERT_BIT] && !(ctrl_two_ff[P4_ALERT_BIT] && p4_in_mode)) |-> !alert_req_out)
        else $error("pin three alert not masked");
    three_dir_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        pin_three_oe_out == (ctrl_two_ff[P3_FUNC_BIT] && !ctrl_two_ff[P3_DIR_BIT]))
        else $error("pin three direction wrong");
    three_pol_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        pin_three_oe_out |-> (pin_three_out == (pin_data_ff[P3_DATA_BIT] == ctrl_two_ff[P3_POL_BIT])))
        else $error("pin three polarity drive wrong");
    four_pol_low_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!p4_in_mode && !ctrl_two_ff[P4_POL_BIT]) |-> (pin_four_out == !pin_data_ff[P4_DATA_BIT]))
        else $error("pin four low drive wrong");
    aux_select_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ctrl_two_ff[P3_FUNC_BIT] |-> !third_aux_select_out)
        else $error("aux input kept in pin mode");
    four_sample_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        four_input_s |=> (pin_data_ff[P4_DATA_BIT] == $past(p4_active)))
        else $error("pin four input not sampled");
    low_two_sample_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (clk_en_in && pin_low_dir_in[0]) |=> (pin_data_ff[P2_DATA_BIT] == $past(pin_low_level_in[0])))
        else $error("pin two input not sampled");
    low_one_sample_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (clk_en_in && pin_low_dir_in[1]) |=> (pin_data_ff[P1_DATA_BIT] == $past(pin_low_level_in[1])))
        else $error("pin one input not sampled");
    reset_state_a: assert property (@(posedge clock_in)
        !rst_b_in |-> ((pin_data_ff == PIN_DATA_RESET) && (ctrl_two_ff == CTRL_TWO_RESET)))
        else $error("registers not cleared in reset");
    ctrl_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ctrl_write_s |=> (ctrl_two_ff == $past(wr_word_in[WORD_DATA_HI -: 8])))
        else $error("control write lost");
    foreign_word_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        foreign_word_s |=> $stable(ctrl_two_ff))
        else $error("word without prefix taken");
    ctrl_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ctrl_read_s |=> (rd_data_out == {4'h0, ctrl_two_ff}))
        else $error("control readback wrong");
    foreign_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (clk_en_in && !rd_hit_out) |=> (rd_data_out == READ_ZERO))
        else $error("foreign address not zero");
endmodule
`default_nettype wire

// File: design/tcg_pkg.sv
/*
 * tcg_pkg: constants for the touch controller pin registers.
 * assumes: the serial front end hands over whole 16-bit write words and a 5-bit read address.
 */
`default_nettype none
package tcg_pkg;
    localparam logic [3:0]  EXT_WRITE_PREFIX = 4'hF;
    localparam logic [3:0]  WADDR_CTRL_TWO   = 4'h1;
    localparam logic [3:0]  WADDR_PIN_DATA   = 4'h2;
    localparam logic [4:0]  RADDR_CTRL_TWO   = 5'h1C;
    localparam logic [4:0]  RADDR_PIN_DATA   = 5'h1D;
    localparam logic [7:0]  CTRL_TWO_RESET   = 8'h00;
    localparam logic [7:0]  PIN_DATA_RESET   = 8'h00;
    localparam logic [7:0]  PIN_DATA_USED    = 8'hF0;
    localparam logic [11:0] READ_ZERO        = 12'h000;
    // control register two fields
    localparam int P4_ALERT_BIT = 0;
    localparam int P4_DIR_BIT   = 1;
    localparam int P4_POL_BIT   = 2;
    localparam int P3_ALERT_BIT = 4;
    localparam int P3_DIR_BIT   = 5;
    localparam int P3_POL_BIT   = 6;
    localparam int P3_FUNC_BIT  = 7;
    // pin data fields
    localparam int P4_DATA_BIT  = 4;
    localparam int P3_DATA_BIT  = 5;
    localparam int P2_DATA_BIT  = 6;
    localparam int P1_DATA_BIT  = 7;
    // write word fields
    localparam int WORD_PREFIX_HI = 15;
    localparam int WORD_ADDR_HI   = 11;
    localparam int WORD_DATA_HI   = 7;
endpackage
`default_nettype wire

// File: verif/tcg_host_model.sv
/* tcg_host_model: serial host stand-in, issues write words and read addresses.
   assumes: the bench calls its tasks; every change lands on a falling edge. */
`default_nettype none
module tcg_host_model (
    input  wire logic        clock_in,
    input  wire logic [11:0] rd_data_in,
    output logic             wr_valid_out,
    output logic      [15:0] wr_word_out,
    output logic      [4:0]  rd_addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_valid_out = 1'b0;
        wr_word_out  = 16'h0000;
        rd_addr_out  = 5'h00;
    end
    // word bits turn over once released, so a stale word is never mistaken for a new one
    task automatic wr(input logic [15:0] w);
        @(negedge clock_in);
        wr_valid_out = 1'b1;
        wr_word_out  = w;
        @(negedge clock_in);
        wr_valid_out = 1'b0;
        wr_word_out  = ~w;
    endtask
    task automatic rd(input logic [4:0] a, output logic [11:0] d);
        @(negedge clock_in);
        rd_addr_out = a;
        @(negedge clock_in);
        d = rd_data_in;
    endtask
endmodule
`default_nettype wire

// File: verif/touch_ctrl_gpio_regs_bench.sv
/* touch_ctrl_gpio_regs_bench: self-checking bench for the pin registers.
   assumes: host model drives the register port; bench drives pins and reset. */
`default_nettype none
module touch_ctrl_gpio_regs_bench;
    import tcg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in, rst_b_in, clk_en, p3_in, p4_in, wr_v, hit, p3_o, p3_oe, p4_o, p4_oe, aux, alert;
    logic [1:0]  lo_dir, lo_lvl, lo_val;
    logic [15:0] wr_w;
    logic [4:0]  rd_a;
    logic [11:0] rd_d, got;
    int          bad_count, tests_run;
    tcg_host_model u_host (.clock_in(clock_in), .rd_data_in(rd_d), .wr_valid_out(wr_v), .wr_word_out(wr_w),
        .rd_addr_out(rd_a));
    tcg_pin_regs u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en), .wr_valid_in(wr_v),
        .wr_word_in(wr_w), .rd_addr_in(rd_a), .rd_data_out(rd_d), .rd_hit_out(hit), .pin_three_in(p3_in),
        .pin_three_out(p3_o), .pin_three_oe_out(p3_oe), .pin_four_in(p4_in), .pin_four_out(p4_o),
        .pin_four_oe_out(p4_oe), .pin_low_dir_in(lo_dir), .pin_low_level_in(lo_lvl), .pin_low_value_out(lo_val),
        .third_aux_select_out(aux), .alert_req_out(alert));
    task automatic chk(input logic [11:0] g, input logic [11:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic close_out;
        $display("tests %0d bad %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_reset;
        u_host.rd(RADDR_PIN_DATA, got);
        chk(got, 12'h000, "data reset");
        chk({9'h000, p4_oe, p3_oe, aux}, 12'h005, "reset pins");
        $display("t_reset done");
    endtask
    task automatic t_out;
        u_host.wr({EXT_WRITE_PREFIX, WADDR_CTRL_TWO, 8'h80});
        u_host.wr({EXT_WRITE_PREFIX, WADDR_PIN_DATA, 8'hFF});
        u_host.rd(RADDR_PIN_DATA, got);
        chk(got, 12'h0F0, "data read");
        chk({11'h000, hit}, 12'h001, "hit");
        chk({5'h00, p4_oe, p3_oe, p4_o, p3_o, aux, lo_val}, 12'h063, "low drive");
        u_host.wr({EXT_WRITE_PREFIX, WADDR_CTRL_TWO, 8'hC4});
        u_host.wr(16'hE200);
        clk_en = 1'b0;
        u_host.wr({EXT_WRITE_PREFIX, WADDR_PIN_DATA, 8'h00});
        clk_en = 1'b1;
        chk({5'h00, p4_oe, p3_oe, p4_o, p3_o, aux, lo_val}, 12'h07B, "high drive");
        u_host.rd(RADDR_PIN_DATA, got);
        chk(got, 12'h0F0, "refused write");
        u_host.rd(RADDR_CTRL_TWO, got);
        chk(got, 12'h0C4, "ctrl read");
        u_host.rd(5'h10, got);
        chk(got | {11'h000, hit}, 12'h000, "unmapped");
        $display("t_out done");
    endtask
    task automatic t_in;
        logic [7:0] ctl [5] = '{8'hF7, 8'hF6, 8'hF6, 8'hE7, 8'hE7};
        logic [4:0] p3v = 5'b11100, p4v = 5'b10110, ev = 5'b10100;
        {lo_dir, lo_lvl, p3_in, p4_in} = 6'b111011;
        u_host.wr({EXT_WRITE_PREFIX, WADDR_CTRL_TWO, 8'hF7});
        u_host.rd(RADDR_PIN_DATA, got);
        chk(got, 12'h0B0, "sampled");
        chk({11'h000, p3_oe | p4_oe}, 12'h000, "released");
        for (int i = 0; i < 5; i++) begin
            u_host.wr({EXT_WRITE_PREFIX, WADDR_CTRL_TWO, ctl[i]});
            p3_in = p3v[i];
            p4_in = p4v[i];
            repeat (2) @(negedge clock_in);
            chk({11'h000, alert}, {11'h000, ev[i]}, "alert");
        end
        $display("t_in done");
    endtask
    task automatic t_pol;
        {lo_dir, p3_in, p4_in} = 4'b0001;
        u_host.wr({EXT_WRITE_PREFIX, WADDR_CTRL_TWO, 8'hB3});
        u_host.wr({EXT_WRITE_PREFIX, WADDR_PIN_DATA, 8'hFF});
        u_host.rd(RADDR_PIN_DATA, got);
        chk(got, 12'h0E0, "pin wins");
        chk({10'h000, alert, aux}, 12'h002, "low alert");
        u_host.wr({EXT_WRITE_PREFIX, WADDR_CTRL_TWO, 8'h33});
        repeat (2) @(negedge clock_in);
        chk({9'h000, alert, aux, p3_oe}, 12'h002, "aux mode");
        p4_in = 1'b0;
        @(negedge clock_in);
        chk({11'h000, alert}, 12'h001, "four low alert");
        $display("t_pol done");
    endtask
    task automatic t_again;
        rst_b_in = 1'b0;
        @(negedge clock_in);
        chk({8'h00, p4_oe, p3_oe, aux, alert}, 12'h00A, "held reset");
        @(negedge clock_in);
        rst_b_in = 1'b1;
        u_host.rd(RADDR_PIN_DATA, got);
        chk(got, 12'h000, "data reset again");
        u_host.rd(RADDR_CTRL_TWO, got);
        chk(got, 12'h000, "ctrl reset again");
        $display("t_again done");
    endtask
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    initial begin
        #20000;
        bad_count++;
        close_out();
    end
    initial begin
        {rst_b_in, clk_en, p3_in, p4_in, lo_dir, lo_lvl} = 8'h40;
        repeat (2) @(negedge clock_in);
        rst_b_in = 1'b1;
        t_reset();
        t_out();
        t_in();
        t_pol();
        t_again();
        close_out();
    end
endmodule
`default_nettype wire
